/* File: logic/gie_expander.sv */
// Grouped interrupt expander: flags, enables, acknowledge and vector supply
`timescale 1ns/1ps
`default_nettype none
module gie_expander (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire gie_pkg::gie_src_s src,
  input wire gie_pkg::gie_reg_req_s reg_req,
  output logic [gie_pkg::GIE_DW-1:0] reg_rdata,
  input wire gie_pkg::gie_vec_req_s vec_req,
  input wire gie_pkg::gie_fetch_s fetch,
  output logic fetch_done,
  output logic [gie_pkg::GIE_VW-1:0] fetch_vec,
  output logic [gie_pkg::GIE_NGRP-1:0] cpu_irq
);
  import gie_pkg::*;

  // ------------------------------------------------------------
  // Source mapping
  // ------------------------------------------------------------
  logic [GIE_NSRC-1:0] src_vec;
  always_comb begin
    src_vec = '0;
    src_vec[gie_pos(1, 1)] = src.power_protect_a;
    src_vec[gie_pos(1, 2)] = src.power_protect_b;
    src_vec[gie_pos(1, 4)] = src.external_irq_one;
    src_vec[gie_pos(1, 5)] = src.external_irq_two;
    src_vec[gie_pos(1, 6)] = src.converter_done_event;
    src_vec[gie_pos(1, 7)] = src.cpu_timer0_event;
    src_vec[gie_pos(1, 8)] = src.wake_event;
    src_vec[gie_pos(2, 1)] = src.compare1_event;
    src_vec[gie_pos(2, 2)] = src.compare2_event;
    src_vec[gie_pos(2, 3)] = src.compare3_event;
    src_vec[gie_pos(2, 4)] = src.timer1_period_event;
    src_vec[gie_pos(2, 5)] = src.timer1_compare_event;
    src_vec[gie_pos(2, 6)] = src.timer1_underflow_event;
    src_vec[gie_pos(2, 7)] = src.timer1_overflow_event;
    src_vec[gie_pos(3, 1)] = src.timer2_period_event;
    src_vec[gie_pos(3, 2)] = src.timer2_compare_event;
    src_vec[gie_pos(3, 3)] = src.timer2_underflow_event;
    src_vec[gie_pos(3, 4)] = src.timer2_overflow_event;
    src_vec[gie_pos(3, 5)] = src.capture1_event;
    src_vec[gie_pos(3, 6)] = src.capture2_event;
    src_vec[gie_pos(3, 7)] = src.capture3_event;
    src_vec[gie_pos(4, 1)] = src.compare4_event;
    src_vec[gie_pos(4, 2)] = src.compare5_event;
    src_vec[gie_pos(4, 3)] = src.compare6_event;
    src_vec[gie_pos(4, 4)] = src.timer3_period_event;
    src_vec[gie_pos(4, 5)] = src.timer3_compare_event;
    src_vec[gie_pos(4, 6)] = src.timer3_underflow_event;
    src_vec[gie_pos(4, 7)] = src.timer3_overflow_event;
    src_vec[gie_pos(5, 1)] = src.timer4_period_event;
    src_vec[gie_pos(5, 2)] = src.timer4_compare_event;
    src_vec[gie_pos(5, 3)] = src.timer4_underflow_event;
    src_vec[gie_pos(5, 4)] = src.timer4_overflow_event;
    src_vec[gie_pos(5, 5)] = src.capture4_event;
    src_vec[gie_pos(5, 6)] = src.capture5_event;
    src_vec[gie_pos(5, 7)] = src.capture6_event;
    src_vec[gie_pos(6, 1)] = src.serial_periph_rx_event;
    src_vec[gie_pos(6, 2)] = src.serial_periph_tx_event;
    src_vec[gie_pos(6, 5)] = src.buffered_port_rx_event;
    src_vec[gie_pos(6, 6)] = src.buffered_port_tx_event;
    src_vec[gie_pos(9, 1)] = src.async_a_rx_event;
    src_vec[gie_pos(9, 2)] = src.async_a_tx_event;
    src_vec[gie_pos(9, 3)] = src.async_b_rx_event;
    src_vec[gie_pos(9, 4)] = src.async_b_tx_event;
    src_vec[gie_pos(9, 5)] = src.can_line0_event;
    src_vec[gie_pos(9, 6)] = src.can_line1_event;
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [GIE_DW-1:0] ctrl, next_ctrl;
  logic [GIE_NGRP-1:0] ack, next_ack;
  logic [GIE_NGRP-1:0][GIE_NPOS-1:0] ier, next_ier;
  logic [GIE_NGRP-1:0][GIE_NPOS-1:0] flag, next_flag;
  logic [GIE_NSRC-1:0] src_q, next_src_q;
  logic [GIE_DW-1:0] next_rdata;
  logic next_done;
  logic [GIE_VW-1:0] next_vec;
  logic [GIE_VW-1:0] vec_tab [GIE_NSRC];
  logic vec_we;
  logic enabled;
  logic [GIE_NSRC-1:0] src_rise;

  assign enabled = ctrl[GIE_CTRL_EN_BIT];
  assign src_rise = src_vec & ~src_q;
  assign vec_we = vec_req.wr && vec_req.priv && (int'(vec_req.idx) < GIE_NSRC);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [GIE_NPOS-1:0] pend;
    int pick;
    int fg;
    pend = '0;
    pick = 0;
    fg = int'(fetch.num) - 1;
    next_ctrl = ctrl;
    next_ack = ack;
    next_ier = ier;
    next_flag = flag;
    next_src_q = src_vec;
    next_rdata = '0;
    next_done = 1'b0;
    next_vec = '0;
    // Register writes, no privilege needed
    if (reg_req.sel && reg_req.wr) begin
      if (reg_req.idx == GIE_REG_CTRL) begin
        next_ctrl = reg_req.wdata;
      end
      if (reg_req.idx == GIE_REG_ACK) begin
        next_ack = ack & ~reg_req.wdata[GIE_NGRP-1:0];
      end
    end
    for (int g = 0; g < GIE_NGRP; g++) begin
      if (reg_req.sel && reg_req.wr && reg_req.idx == 5'(int'(GIE_REG_IER0) + GIE_REG_STRIDE * g)) begin
        next_ier[g] = reg_req.wdata[GIE_NPOS-1:0];
      end
      if (reg_req.sel && reg_req.wr && reg_req.idx == 5'(int'(GIE_REG_IFR0) + GIE_REG_STRIDE * g)) begin
        next_flag[g] = reg_req.wdata[GIE_NPOS-1:0];
      end
      if (reg_req.sel && reg_req.idx == 5'(int'(GIE_REG_IER0) + GIE_REG_STRIDE * g)) begin
        next_rdata = {{(GIE_DW-GIE_NPOS){1'b0}}, ier[g]};
      end
      if (reg_req.sel && reg_req.idx == 5'(int'(GIE_REG_IFR0) + GIE_REG_STRIDE * g)) begin
        next_rdata = {{(GIE_DW-GIE_NPOS){1'b0}}, flag[g]};
      end
    end
    if (reg_req.sel && reg_req.idx == GIE_REG_CTRL) begin
      next_rdata = ctrl;
    end
    if (reg_req.sel && reg_req.idx == GIE_REG_ACK) begin
      next_rdata = {{(GIE_DW-GIE_NGRP){1'b0}}, ack};
    end
    // Vector fetch and software vector calls
    if (fetch.req) begin
      next_done = 1'b1;
      if (fetch.trap) begin
        // Call zero falls here and returns zero; software must avoid it
        if (enabled && fetch.num >= GIE_TRAP_MIN && fetch.num <= GIE_TRAP_MAX) begin
          next_vec = vec_tab[gie_pos(fg + 1, 1)];
        end
      end else if (enabled && fetch.num >= GIE_TRAP_MIN && fetch.num <= GIE_TRAP_MAX) begin
        pend = flag[fg] & ier[fg];
        for (int p = GIE_NPOS - 1; p >= 0; p--) begin
          if (pend[p]) begin
            pick = p;
          end
        end
        next_vec = vec_tab[fg * GIE_NPOS + pick];
        if (pend != '0) begin
          next_flag[fg][pick] = 1'b0;
        end
        next_ack[fg] = 1'b1;
      end
    end
    // New source edges win over any clear in the same cycle
    for (int g = 0; g < GIE_NGRP; g++) begin
      next_flag[g] = next_flag[g] | src_rise[g*GIE_NPOS +: GIE_NPOS];
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl <= GIE_CTRL_RST;
      ack <= '0;
      ier <= '0;
      flag <= '0;
      src_q <= '0;
      reg_rdata <= '0;
      fetch_done <= 1'b0;
      fetch_vec <= '0;
      for (int i = 0; i < GIE_NSRC; i++) begin
        vec_tab[i] <= GIE_VEC_RST;
      end
    end else begin
      ctrl <= next_ctrl;
      ack <= next_ack;
      ier <= next_ier;
      flag <= next_flag;
      src_q <= next_src_q;
      reg_rdata <= next_rdata;
      fetch_done <= next_done;
      fetch_vec <= next_vec;
      if (vec_we) begin
        vec_tab[vec_req.idx] <= vec_req.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // CPU lines
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < GIE_NGRP; gi++) begin : g_line
      assign cpu_irq[gi] = enabled && !ack[gi] && ((flag[gi] & ier[gi]) != '0);
    end
  endgenerate
endmodule
`default_nettype wire

/* File: logic/gie_pkg.sv */
// Constants and carrier types of the grouped interrupt expander
package gie_pkg;
  localparam int GIE_NGRP = 12;
  localparam int GIE_NPOS = 8;
  localparam int GIE_NSRC = GIE_NGRP * GIE_NPOS;
  localparam int GIE_DW = 16;
  localparam int GIE_VW = 32;
  localparam int GIE_AW = 7;
  // Word index of each register on the core access port
  localparam logic [4:0] GIE_REG_CTRL = 5'h00;
  localparam logic [4:0] GIE_REG_ACK = 5'h01;
  localparam logic [4:0] GIE_REG_IER0 = 5'h02;
  localparam logic [4:0] GIE_REG_IFR0 = 5'h03;
  localparam int GIE_REG_STRIDE = 2;
  localparam int GIE_CTRL_EN_BIT = 0;
  localparam logic [GIE_DW-1:0] GIE_CTRL_RST = 16'h0000;
  localparam logic [GIE_VW-1:0] GIE_VEC_RST = 32'h0000_0000;
  localparam logic [3:0] GIE_TRAP_MIN = 4'h1;
  localparam logic [3:0] GIE_TRAP_MAX = 4'hc;

  // Flat position of group g, position p (both counted from 1)
  function automatic int gie_pos(input int g, input int p);
    return (g - 1) * GIE_NPOS + (p - 1);
  endfunction

  typedef struct packed {
    logic power_protect_a, power_protect_b, external_irq_one, external_irq_two;
    logic converter_done_event, cpu_timer0_event, wake_event;
    logic compare1_event, compare2_event, compare3_event;
    logic timer1_period_event, timer1_compare_event, timer1_underflow_event, timer1_overflow_event;
    logic timer2_period_event, timer2_compare_event, timer2_underflow_event, timer2_overflow_event;
    logic capture1_event, capture2_event, capture3_event;
    logic compare4_event, compare5_event, compare6_event;
    logic timer3_period_event, timer3_compare_event, timer3_underflow_event, timer3_overflow_event;
    logic timer4_period_event, timer4_compare_event, timer4_underflow_event, timer4_overflow_event;
    logic capture4_event, capture5_event, capture6_event;
    logic serial_periph_rx_event, serial_periph_tx_event;
    logic buffered_port_rx_event, buffered_port_tx_event;
    logic async_a_rx_event, async_a_tx_event, async_b_rx_event, async_b_tx_event;
    logic can_line0_event, can_line1_event;
  } gie_src_s;

  typedef struct packed {
    logic req;
    logic trap;
    logic [3:0] num;
  } gie_fetch_s;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [4:0] idx;
    logic [GIE_DW-1:0] wdata;
  } gie_reg_req_s;

  typedef struct packed {
    logic wr;
    logic priv;
    logic [GIE_AW-1:0] idx;
    logic [GIE_VW-1:0] wdata;
  } gie_vec_req_s;
endpackage

/* File: tb/gie_expander_asserts.sv */
// Port-level assertions for the grouped interrupt expander
`timescale 1ns/1ps
`default_nettype none
module gie_expander_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire gie_pkg::gie_src_s src,
  input wire gie_pkg::gie_reg_req_s reg_req,
  input wire logic [gie_pkg::GIE_DW-1:0] reg_rdata,
  input wire gie_pkg::gie_vec_req_s vec_req,
  input wire gie_pkg::gie_fetch_s fetch,
  input wire logic fetch_done,
  input wire logic [gie_pkg::GIE_VW-1:0] fetch_vec,
  input wire logic [gie_pkg::GIE_NGRP-1:0] cpu_irq
);
  import gie_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Fetch port
  // ----
  done_after_req_a: assert property (fetch.req |=> fetch_done) else $error("no done");
  done_needs_req_a: assert property (fetch_done |-> $past(fetch.req)) else $error("stray done");
  vec_idle_zero_a: assert property (!fetch_done |-> fetch_vec == '0) else $error("vec not zero");
  call_zero_vec_a: assert property (fetch.req && fetch.num == 4'h0 |=> fetch_vec == '0) else $error("call 0");
  irq_drop_fetch_a: assert property (fetch.req && !fetch.trap && fetch.num inside {[GIE_TRAP_MIN:GIE_TRAP_MAX]}
    |=> !cpu_irq[$past(fetch.num) - 4'h1]) else $error("line stays up");
  ctrl_off_quiet_a: assert property (reg_req.sel && reg_req.wr && reg_req.idx == GIE_REG_CTRL
    && !reg_req.wdata[GIE_CTRL_EN_BIT] |=> cpu_irq == '0) else $error("line while off");
  // ----
  // Register port
  // ----
  rdata_idle_zero_a: assert property (!reg_req.sel |=> reg_rdata == '0) else $error("rdata idle");
  unmapped_read_a: assert property (reg_req.sel && reg_req.idx > 5'h19 |=> reg_rdata == '0) else $error("hole");
  reset_quiet_a: assert property ($fell(sys_rst) |-> cpu_irq == '0 && !fetch_done) else $error("reset state");
  cover property (fetch.req && fetch.trap);
  cover property ($rose(|cpu_irq));
  cover property (reg_req.sel && reg_req.wr);
endmodule
bind gie_expander gie_expander_asserts gie_expander_asserts_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .src(src), .reg_req(reg_req), .reg_rdata(reg_rdata), .vec_req(vec_req), .fetch(fetch),
  .fetch_done(fetch_done), .fetch_vec(fetch_vec), .cpu_irq(cpu_irq));
`default_nettype wire

/* File: tb/gie_cpu_model.sv */
// CPU core model issuing vector fetches and software calls
`timescale 1ns/1ps
`default_nettype none
module gie_cpu_model (
  input wire logic core_clk,
  input wire logic fetch_done,
  input wire logic [gie_pkg::GIE_VW-1:0] fetch_vec,
  output var gie_pkg::gie_fetch_s fetch
);
  import gie_pkg::*;
  initial fetch = '0;
  // ----
  // One request at a time, answer taken the cycle after
  // ----
  task automatic fetch_one(input logic trap, input logic [3:0] num, output logic done, output logic [GIE_VW-1:0] vec);
    @(negedge core_clk);
    fetch <= '{1'b1, trap, num};
    @(negedge core_clk);
    // Released fields show garbage, not the last value
    fetch <= '{1'b0, ~trap, ~num};
    done = fetch_done;
    vec = fetch_vec;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the grouped interrupt expander
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gie_pkg::*;
  logic core_clk, sys_rst, fetch_done, done;
  gie_src_s src;
  gie_reg_req_s reg_req;
  gie_vec_req_s vec_req;
  gie_fetch_s fetch;
  logic [GIE_DW-1:0] reg_rdata, rd;
  logic [GIE_VW-1:0] fetch_vec, v;
  logic [GIE_NGRP-1:0] cpu_irq;
  logic [GIE_VW-1:0] vv [GIE_NSRC];
  int bad_count = 0, samples_checked = 0, cycles = 0, seed, g, p;
  // Flat position of each source field, most significant field first
  byte pmap [45] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16, 17, 18, 19, 20, 21, 22, 24, 25, 26,
    27, 28, 29, 30, 32, 33, 34, 35, 36, 37, 38, 40, 41, 44, 45, 64, 65, 66, 67, 68, 69};
  gie_expander gie_expander_inst (.core_clk(core_clk), .sys_rst(sys_rst), .src(src), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .vec_req(vec_req), .fetch(fetch), .fetch_done(fetch_done), .fetch_vec(fetch_vec),
    .cpu_irq(cpu_irq));
  gie_cpu_model gie_cpu_model_inst (.core_clk(core_clk), .fetch_done(fetch_done), .fetch_vec(fetch_vec),
    .fetch(fetch));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      $display("Error at %0t: run timed out", $time);
      test_done();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_acc(input logic wr, input logic [4:0] idx, input logic [15:0] wd);
    @(negedge core_clk);
    reg_req <= '{1'b1, wr, idx, wd};
    @(negedge core_clk);
    reg_req <= '0;
    rd = reg_rdata;
  endtask
  task automatic vec_wr(input logic priv, input int i, input logic [GIE_VW-1:0] wd);
    @(negedge core_clk);
    vec_req <= '{1'b1, priv, GIE_AW'(i), wd};
    @(negedge core_clk);
    vec_req <= '0;
  endtask
  task automatic pulse(input int k);
    @(negedge core_clk);
    src <= gie_src_s'(45'h1 << (44 - k));
    @(negedge core_clk);
    src <= '0;
  endtask
  task automatic call(input logic trap, input int n, input logic [GIE_VW-1:0] exp);
    gie_cpu_model_inst.fetch_one(trap, 4'(n), done, v);
    chk(32'(done), 32'h1);
    chk(v, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    seed = 93766;
    src = '0;
    reg_req = '0;
    vec_req = '0;
    sys_rst = 1'b1;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      reg_acc(1'b0, 5'(i), 16'h0);
      chk(32'(rd), 32'h0);
    end
    reg_acc(1'b1, 5'h1f, 16'hffff);
    reg_acc(1'b0, 5'h1f, 16'h0);
    chk(32'(rd), 32'h0);
    $display("test registers done");
    for (int i = 0; i < GIE_NSRC; i++) begin
      vv[i] = $random(seed);
      vec_wr(1'b1, i, vv[i]);
    end
    vec_wr(1'b0, 0, ~vv[0]);
    reg_acc(1'b1, GIE_REG_CTRL, 16'h0001);
    reg_acc(1'b0, GIE_REG_CTRL, 16'h0);
    chk(32'(rd), 32'h1);
    for (int i = 0; i < GIE_NGRP; i++) reg_acc(1'b1, GIE_REG_IER0 + 5'(2 * i), 16'h00ff);
    for (int n = 1; n <= GIE_NGRP; n++) call(1'b1, n, vv[(n - 1) * GIE_NPOS]);
    chk(32'(cpu_irq), 32'h0);
    $display("test calls done");
    for (int k = 0; k < 45; k++) begin
      g = pmap[k] / GIE_NPOS;
      p = pmap[k] % GIE_NPOS;
      pulse(k);
      chk(32'(cpu_irq), 32'h1 << g);
      reg_acc(1'b0, GIE_REG_IFR0 + 5'(2 * g), 16'h0);
      chk(32'(rd), 32'h1 << p);
      call(1'b0, g + 1, vv[pmap[k]]);
      chk(32'(cpu_irq), 32'h0);
      reg_acc(1'b1, GIE_REG_ACK, 16'(1 << g));
    end
    $display("test sources done");
    // Group 12 has no sources, so flag writes there cannot lose events
    reg_acc(1'b1, GIE_REG_IFR0 + 5'd22, 16'h0080);
    chk(32'(cpu_irq), 32'h800);
    call(1'b0, 12, vv[95]);
    reg_acc(1'b1, GIE_REG_IFR0 + 5'd22, 16'h0001);
    chk(32'(cpu_irq), 32'h0);
    reg_acc(1'b1, GIE_REG_ACK, 16'h0800);
    chk(32'(cpu_irq), 32'h800);
    call(1'b0, 12, vv[88]);
    // Source edge and flag clear in one cycle: the edge must survive
    @(negedge core_clk);
    src <= gie_src_s'(45'h1 << (44 - 7));
    reg_req <= '{1'b1, 1'b1, GIE_REG_IFR0 + 5'd2, 16'h0000};
    @(negedge core_clk);
    src <= '0;
    reg_req <= '0;
    chk(32'(cpu_irq), 32'h2);
    call(1'b0, 2, vv[8]);
    reg_acc(1'b1, GIE_REG_ACK, 16'h0002);
    // Nothing pending: position 1 entry comes back
    call(1'b0, 2, vv[8]);
    reg_acc(1'b1, GIE_REG_ACK, 16'h0002);
    chk(32'(cpu_irq), 32'h0);
    call(1'b0, 13, 32'h0);
    reg_acc(1'b1, GIE_REG_CTRL, 16'h0);
    call(1'b1, 5, 32'h0);
    // Call zero only issued once the expander is off
    call(1'b1, 0, 32'h0);
    $display("test software interrupts done");
    test_done();
  end
endmodule
`default_nettype wire
